// [dacrc_map.svh]
`ifndef DACRC_MAP_SVH
`define DACRC_MAP_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define DACRC_OFF_CTRL0 4'h0
`define DACRC_OFF_CTRL1 4'h4
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DACRC_BIT_EN 7
`define DACRC_BIT_OE1 5
`define DACRC_BIT_OE2 4
`define DACRC_PSS_HI 3
`define DACRC_PSS_LO 2
`define DACRC_BIT_NSS 0
`define DACRC_SEL_LANE0 0
`define DACRC_LVL_HI 4
`define DACRC_LVL_LO 0
// ----------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------
`define DACRC_CTRL0_MASK 8'hBD
`define DACRC_CTRL1_MASK 8'h1F
`define DACRC_CTRL0_RST 8'h00
`define DACRC_CTRL1_RST 8'h00
`define DACRC_ZERO32 32'h0000_0000
`endif

// [dacrc_pkg.sv]
`default_nettype none
package dacrc_pkg;
  typedef logic [7:0] dacrc_reg_t;
  typedef enum logic [1:0] {
    DACRC_PSS_SUPPLY,
    DACRC_PSS_VREF_PIN,
    DACRC_PSS_FIXED_REF,
    DACRC_PSS_RESERVED
  } dacrc_pss_e;
endpackage
`default_nettype wire

// [dacrc_pin_ovr.sv]
`timescale 1ns/100ps
`default_nettype none
module dacrc_pin_ovr
  import dacrc_pkg::*;
(
  input wire logic i_sel,
  input wire logic i_port_out,
  input wire logic i_port_oe,
  input wire logic i_port_in,
  input wire logic i_pullup_en,
  input wire logic i_cur_drv_en,
  output logic o_pin_out,
  output logic o_pin_oe,
  output logic o_pin_in,
  output logic o_pullup_en,
  output logic o_cur_drv_en,
  output logic o_analog_sel
);
  // ----------------------------------------------------------------
  // Pin takeover
  // ----------------------------------------------------------------
  always_comb
  begin
    o_pin_out = i_sel ? 1'b0 : i_port_out;
    o_pin_oe = i_sel ? 1'b0 : i_port_oe;
    o_pullup_en = i_sel ? 1'b0 : i_pullup_en;
    o_cur_drv_en = i_sel ? 1'b0 : i_cur_drv_en;
    o_pin_in = i_sel ? 1'b0 : i_port_in;
    o_analog_sel = i_sel;
  end
endmodule // dacrc_pin_ovr
`default_nettype wire

// [dacrc_top.sv]
// Functional notes
// - Reference voltage routed to pin one/two when bit 5/bit 4 set.
// - Selected pin loses digital buffer, input detector, pull-up, current drive.
// - Reading a selected reference pin always returns zero.
// - Control keeps working and holds settings during sleep.
// - Wake from sleep leaves first control register unchanged.
// - Reset disables converter and withdraws reference from both pins.
// - Reset clears five-bit level code to zero.
// - Ctrl0: enable bit7, pin enables bits5/4, positive source 3-2, negative bit0.
// - Ctrl1 bits 4-0 hold level code, code over 32 steps.
// - Converter active only while enable bit is set.
`include "dacrc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module dacrc_top
  import dacrc_pkg::*;
#(
  parameter int LVL_W = 5
)
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_SLEEP,
  input wire logic I_WAKE,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [3:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic [1:0] I_PORT_OUT,
  input wire logic [1:0] I_PORT_OE,
  input wire logic [1:0] I_PIN_IN,
  input wire logic [1:0] I_PULLUP_EN,
  input wire logic [1:0] I_CUR_DRV_EN,
  output logic [1:0] O_PIN_OUT,
  output logic [1:0] O_PIN_OE,
  output logic [1:0] O_PORT_IN,
  output logic [1:0] O_PULLUP_EN,
  output logic [1:0] O_CUR_DRV_EN,
  output logic [1:0] O_REF_PIN_SEL,
  output logic O_CONV_ACTIVE,
  output logic [1:0] O_POS_SRC_SEL,
  output logic O_NEG_SRC_SEL,
  output logic [LVL_W-1:0] O_LEVEL_CODE
);
  // ----------------------------------------------------------------
  // Local sizes
  // ----------------------------------------------------------------
  localparam int DAT_W = 32;
  localparam int REG_W = 8;
  localparam int PIN_N = 2;
  localparam dacrc_reg_t CTRL0_RST = `DACRC_CTRL0_RST;
  localparam dacrc_reg_t CTRL1_RST = `DACRC_CTRL1_RST;

  // ----------------------------------------------------------------
  // Bus states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    DACRC_BUS_IDLE,
    DACRC_BUS_ACK
  } dacrc_bus_e;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dacrc_bus_e bus_state_ff;
  dacrc_bus_e nxt_bus_state;
  logic bus_sel;
  logic take;
  logic commit;
  logic lane0_wr;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic [REG_W-1:0] wr_byte;
  logic en_ff;
  logic oe1_ff;
  logic oe2_ff;
  dacrc_pss_e pss_ff;
  logic nss_ff;
  logic [LVL_W-1:0] lvl_ff;
  dacrc_reg_t ctrl0_view;
  dacrc_reg_t ctrl1_view;
  dacrc_reg_t nxt_rdat;
  logic [DAT_W-1:0] rdat_ff;
  logic [PIN_N-1:0] pin_sel;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  assign bus_sel = I_WB_CYC && I_WB_STB;
  // Taken only while no answer is pending
  assign take = bus_sel && (bus_state_ff == DACRC_BUS_IDLE);
  // Writes land on the edge that samples ack high
  assign commit = bus_sel && (bus_state_ff == DACRC_BUS_ACK);

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  // One-cycle ack after each taken request
  always_comb
  begin
    nxt_bus_state = bus_state_ff;
    case (bus_state_ff)
      DACRC_BUS_IDLE:
      begin
        if (take)
        begin
          nxt_bus_state = DACRC_BUS_ACK;
        end
      end
      DACRC_BUS_ACK:
      begin
        nxt_bus_state = DACRC_BUS_IDLE;
      end
      default:
      begin
        nxt_bus_state = DACRC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      bus_state_ff <= DACRC_BUS_IDLE;
    end
    else
    begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // only byte lane zero carries bits
  assign lane0_wr = commit && I_WB_WE && I_WB_SEL[`DACRC_SEL_LANE0];
  assign wr_byte = I_WB_DAT[REG_W-1:0];
  assign wr_ctrl0 = lane0_wr && (I_WB_ADR == `DACRC_OFF_CTRL0);
  assign wr_ctrl1 = lane0_wr && (I_WB_ADR == `DACRC_OFF_CTRL1);

  // ----------------------------------------------------------------
  // Converter enable
  // ----------------------------------------------------------------
  // sleep and wake ignored
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      en_ff <= CTRL0_RST[`DACRC_BIT_EN];
    end
    else if (wr_ctrl0)
    begin
      en_ff <= wr_byte[`DACRC_BIT_EN];
    end
  end

  // ----------------------------------------------------------------
  // Pin one routing
  // ----------------------------------------------------------------
  // sleep and wake ignored
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      oe1_ff <= CTRL0_RST[`DACRC_BIT_OE1];
    end
    else if (wr_ctrl0)
    begin
      oe1_ff <= wr_byte[`DACRC_BIT_OE1];
    end
  end

  // ----------------------------------------------------------------
  // Pin two routing
  // ----------------------------------------------------------------
  // sleep and wake ignored
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      oe2_ff <= CTRL0_RST[`DACRC_BIT_OE2];
    end
    else if (wr_ctrl0)
    begin
      oe2_ff <= wr_byte[`DACRC_BIT_OE2];
    end
  end

  // ----------------------------------------------------------------
  // Positive source select
  // ----------------------------------------------------------------
  // sleep and wake ignored
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      pss_ff <= dacrc_pss_e'(CTRL0_RST[`DACRC_PSS_HI:`DACRC_PSS_LO]);
    end
    else if (wr_ctrl0)
    begin
      pss_ff <= dacrc_pss_e'(wr_byte[`DACRC_PSS_HI:`DACRC_PSS_LO]);
    end
  end

  // ----------------------------------------------------------------
  // Negative source select
  // ----------------------------------------------------------------
  // sleep and wake ignored
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      nss_ff <= CTRL0_RST[`DACRC_BIT_NSS];
    end
    else if (wr_ctrl0)
    begin
      nss_ff <= wr_byte[`DACRC_BIT_NSS];
    end
  end

  // ----------------------------------------------------------------
  // Level code
  // ----------------------------------------------------------------
  // sleep keeps level code
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      lvl_ff <= CTRL1_RST[`DACRC_LVL_LO +: LVL_W];
    end
    else if (wr_ctrl1)
    begin
      lvl_ff <= wr_byte[`DACRC_LVL_LO +: LVL_W];
    end
  end

  // ----------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------
  // unimplemented bits read zero
  always_comb
  begin
    ctrl0_view = '0;
    ctrl0_view[`DACRC_BIT_EN] = en_ff;
    ctrl0_view[`DACRC_BIT_OE1] = oe1_ff;
    ctrl0_view[`DACRC_BIT_OE2] = oe2_ff;
    ctrl0_view[`DACRC_PSS_HI:`DACRC_PSS_LO] = pss_ff;
    ctrl0_view[`DACRC_BIT_NSS] = nss_ff;
    ctrl1_view = '0;
    ctrl1_view[`DACRC_LVL_LO +: LVL_W] = lvl_ff;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unmapped offsets read zero
  always_comb
  begin
    case (I_WB_ADR)
      `DACRC_OFF_CTRL0: nxt_rdat = ctrl0_view;
      `DACRC_OFF_CTRL1: nxt_rdat = ctrl1_view;
      default: nxt_rdat = '0;
    endcase
  end

  // Read data stands only in the ack cycle
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      rdat_ff <= '0;
    end
    else if (take && !I_WB_WE)
    begin
      rdat_ff <= DAT_W'(nxt_rdat);
    end
    else
    begin
      rdat_ff <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------
  assign O_WB_ACK = (bus_state_ff == DACRC_BUS_ACK);
  assign O_WB_DAT = rdat_ff;

  // ----------------------------------------------------------------
  // Converter controls
  // ----------------------------------------------------------------
  // active only while enabled
  assign O_CONV_ACTIVE = en_ff;
  assign O_POS_SRC_SEL = pss_ff;
  assign O_NEG_SRC_SEL = nss_ff;
  assign O_LEVEL_CODE = lvl_ff;
  assign pin_sel = {oe2_ff, oe1_ff};
  assign O_REF_PIN_SEL = pin_sel;

  // ----------------------------------------------------------------
  // Pin overrides
  // ----------------------------------------------------------------
  // One takeover cell per reference pin
  genvar g;
  generate
    for (g = 0; g < PIN_N; g++)
    begin : g_pin
      dacrc_pin_ovr u_ovr (
        .i_sel(pin_sel[g]),
        .i_port_out(I_PORT_OUT[g]),
        .i_port_oe(I_PORT_OE[g]),
        .i_port_in(I_PIN_IN[g]),
        .i_pullup_en(I_PULLUP_EN[g]),
        .i_cur_drv_en(I_CUR_DRV_EN[g]),
        .o_pin_out(O_PIN_OUT[g]),
        .o_pin_oe(O_PIN_OE[g]),
        .o_pin_in(O_PORT_IN[g]),
        .o_pullup_en(O_PULLUP_EN[g]),
        .o_cur_drv_en(O_CUR_DRV_EN[g]),
        .o_analog_sel()
      );
    end
  endgenerate
endmodule // dacrc_top
`default_nettype wire

// [dacrc_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module dacrc_chk #(parameter int LVL_W = 5) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [3:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic O_WB_ACK,
  input wire logic [1:0] I_PIN_IN,
  input wire logic [1:0] O_PORT_IN,
  input wire logic [1:0] O_PIN_OUT,
  input wire logic [1:0] O_PIN_OE,
  input wire logic [1:0] O_PULLUP_EN,
  input wire logic [1:0] O_CUR_DRV_EN,
  input wire logic [1:0] O_REF_PIN_SEL,
  input wire logic O_CONV_ACTIVE,
  input wire logic [1:0] O_POS_SRC_SEL,
  input wire logic O_NEG_SRC_SEL,
  input wire logic [LVL_W-1:0] O_LEVEL_CODE
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // Write lands on the edge that samples ack high
  wire w = I_WB_CYC && I_WB_STB && O_WB_ACK && I_WB_WE && I_WB_SEL[0];
  property p_ack; I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK ##1 !O_WB_ACK; endproperty
  a_ack: assert property (p_ack) else $error("ack");
  property p_pin; (O_REF_PIN_SEL & (O_PIN_OUT | O_PIN_OE | O_PULLUP_EN
    | O_CUR_DRV_EN)) == 2'h0; endproperty
  a_pin: assert property (p_pin) else $error("pin");
  property p_in; O_PORT_IN == (I_PIN_IN & ~O_REF_PIN_SEL); endproperty
  a_in: assert property (p_in) else $error("in");
  property p_rst; $rose(I_RST_N) |-> !O_CONV_ACTIVE && O_REF_PIN_SEL == 2'h0
    && O_LEVEL_CODE == '0; endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_en; w && I_WB_ADR == 4'h0 |=> O_CONV_ACTIVE == $past(I_WB_DAT[7]); endproperty
  a_en: assert property (p_en) else $error("en");
  property p_src; w && I_WB_ADR == 4'h0 |=> O_POS_SRC_SEL == $past(I_WB_DAT[3:2])
    && O_NEG_SRC_SEL == $past(I_WB_DAT[0]); endproperty
  a_src: assert property (p_src) else $error("src");
  property p_oe; w && I_WB_ADR == 4'h0 |=> O_REF_PIN_SEL == {$past(I_WB_DAT[4]),
    $past(I_WB_DAT[5])}; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_lvl; w && I_WB_ADR == 4'h4 |=> O_LEVEL_CODE == $past(I_WB_DAT[4:0]); endproperty
  a_lvl: assert property (p_lvl) else $error("lvl");
  property p_hold; !w |=> $stable(O_CONV_ACTIVE) && $stable(O_LEVEL_CODE); endproperty
  a_hold: assert property (p_hold) else $error("hold");
endmodule // dacrc_chk
bind dacrc_top dacrc_chk #(.LVL_W(LVL_W)) u_dacrc_chk (.*);
`default_nettype wire

// [tb.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; $display("ERROR %0t bad", $time); end end
module tb;
  import dacrc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, slp = 1'b0;
  logic wk = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wd = 32'h0, rd, r;
  logic [1:0] pin = 2'h3, po = 2'h3, oe = 2'h3, pu = 2'h3, cd = 2'h3;
  logic [1:0] pout, poe, pinr, puo, cdo, rsel, pss;
  logic [4:0] lvl;
  logic ack, act, nss;
  int err_total = 0, cmp_count = 0;
  // ----
  // Bench
  // ----
  dacrc_top u_dacrc_top (.I_CLK(clk), .I_RST_N(rst_n), .I_SLEEP(slp), .I_WAKE(wk),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
    .I_WB_DAT(wd), .O_WB_DAT(rd), .O_WB_ACK(ack), .I_PORT_OUT(po), .I_PORT_OE(oe),
    .I_PIN_IN(pin), .I_PULLUP_EN(pu), .I_CUR_DRV_EN(cd), .O_PIN_OUT(pout), .O_PIN_OE(poe),
    .O_PORT_IN(pinr), .O_PULLUP_EN(puo), .O_CUR_DRV_EN(cdo), .O_REF_PIN_SEL(rsel),
    .O_CONV_ACTIVE(act), .O_POS_SRC_SEL(pss), .O_NEG_SRC_SEL(nss), .O_LEVEL_CODE(lvl));
  initial forever #25 clk = ~clk;
  task automatic finish_test;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
    input logic [31:0] d);
    int n = 0;
    {cyc, stb, we, adr, sel, wd} <= {2'h3, w, a, s, d};
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rd;
    {cyc, stb} <= 2'h0;
    @(posedge clk);
    if (n >= 20)
    begin
      err_total++;
      finish_test;
    end
  endtask
  task automatic t_regs;
    wb(1'b0, 4'h0, 4'hF, 32'h0);
    `CHK(r, 32'h0)
    wb(1'b1, 4'h0, 4'hF, 32'hFFFF_FFFF);
    wb(1'b0, 4'h0, 4'hF, 32'h0);
    `CHK(r, 32'h0000_00BD)
    `CHK({act, pss, nss}, 4'hF)
    wb(1'b1, 4'h4, 4'hF, 32'hFFFF_FFFF);
    wb(1'b1, 4'h4, 4'hE, 32'h0);
    wb(1'b0, 4'h4, 4'hF, 32'h0);
    `CHK(r, 32'h0000_001F)
    wb(1'b1, 4'h8, 4'hF, 32'hFF);
    wb(1'b0, 4'h8, 4'hF, 32'h0);
    `CHK(r, 32'h0)
    $display("regs end");
  endtask
  task automatic t_pins;
    logic [1:0] m;
    for (int i = 0; i < 4; i++)
    begin
      m = i[1:0];
      wb(1'b1, 4'h0, 4'hF, {26'h0, m[0], m[1], 4'h0});
      `CHK(rsel, m)
      `CHK({pout, poe, puo, cdo, pinr}, {5{~m}})
      `CHK(act, 1'b0)
    end
    $display("pins end");
  endtask
  task automatic t_sleep;
    wb(1'b1, 4'h0, 4'hF, 32'h0000_00A5);
    wb(1'b1, 4'h4, 4'hF, 32'h0000_0015);
    slp <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK({act, rsel, lvl, pinr}, {8'hB5, 2'h2})
    {slp, wk} <= 2'h1;
    @(posedge clk);
    wk <= 1'b0;
    @(posedge clk);
    `CHK({act, rsel, lvl}, 8'hB5)
    wb(1'b0, 4'h0, 4'hF, 32'h0);
    `CHK(r, 32'h0000_00A5)
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK({act, rsel, lvl, pout}, 10'h003)
    wb(1'b0, 4'h4, 4'hF, 32'h0);
    `CHK(r, 32'h0)
    $display("sleep end");
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_pins;
    t_sleep;
    finish_test;
  end
endmodule // tb
`default_nettype wire
